//--- hw/mce_pkg.sv
// shared types and constants for the call/jump/add/and/compare executor
// assumes a single core clock and synchronous-read internal ram
package mce_pkg;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_PTR = 3'b001, S_PTRG = 3'b010, S_RD = 3'b011,
    S_EXEC = 3'b100, S_WB = 3'b101, S_PUSHL = 3'b110, S_PUSHH = 3'b111
  } mce_fsm_t;
  typedef enum logic [2:0] {
    K_ADD = 3'b000, K_ADD_WITH_CARRY = 3'b001, K_ANLA = 3'b010, K_ANLD = 3'b011,
    K_ANLC = 3'b100, K_ANLCN = 3'b101, K_COMPARE_BRANCH_UNEQUAL = 3'b110, K_NONE = 3'b111
  } mce_op_t;
  // opcode groups (upper nibble) and source kinds (lower nibble)
  localparam logic [3:0] G_ADD = 4'h2;
  localparam logic [3:0] G_ADD_WITH_CARRY = 4'h3;
  localparam logic [3:0] G_ANL = 4'h5;
  localparam logic [3:0] G_COMPARE_BRANCH_UNEQUAL = 4'hB;
  localparam logic [3:0] LO_IMM = 4'h4;
  localparam logic [3:0] LO_DIR = 4'h5;
  localparam logic [3:0] LO_IND = 4'h6;
  localparam logic [3:0] LO_REG = 4'h8;
  localparam logic [4:0] CALL_LO = 5'h11;
  localparam logic [4:0] JMP_LO = 5'h01;
  localparam logic [7:0] OP_ANL_DA = 8'h52;
  localparam logic [7:0] OP_ANL_DI = 8'h53;
  localparam logic [7:0] OP_ANL_CB = 8'h82;
  localparam logic [7:0] OP_ANL_CNB = 8'hB0;
  // status word bit positions
  localparam int PSW_CY = 7;
  localparam int PSW_AC = 6;
  localparam int PSW_OV = 2;
  localparam int PSW_RS1 = 4;
  localparam int PSW_RS0 = 3;
  localparam logic [7:0] SP_RST = 8'h07;
  // bit space and special-register map
  localparam logic [7:0] BIT_RAM_BASE = 8'h20;
  localparam logic [7:0] BIT_SFR_MASK = 8'hF8;
  localparam logic [7:0] SFR_ACC = 8'hE0;
  localparam logic [7:0] SFR_PSW = 8'hD0;
  localparam logic [7:0] SFR_SP = 8'h81;
  localparam logic [7:0] PORT_MASK = 8'hCF;
  localparam logic [7:0] PORT_BASE = 8'h80;
  localparam int PORT_IDX_HI = 5;
  localparam int PORT_IDX_LO = 4;
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] b1;
    logic [7:0] b2;
  } mce_ins_t;
  typedef struct packed {
    logic en;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mce_ram_req_t;
  typedef struct packed {
    mce_fsm_t fsm;
    mce_op_t kind;
    logic [15:0] pc;
    logic [7:0] sp;
    logic [7:0] acc;
    logic [7:0] psw;
    logic [3:0][7:0] latch;
    logic [3:0][7:0] pin1;
    logic [3:0][7:0] pin2;
    logic [7:0] addr;
    logic [7:0] imm;
    logic [7:0] rel;
    logic [7:0] res;
    logic [10:0] tgt;
    logic [2:0] bpos;
    logic ind;
    logic fetch;
    logic afirst;
  } mce_state_t;
endpackage

//--- hw/mce_exec.sv
// executor for absolute call/jump, add, add with carry, byte/bit and,
// and compare-branch; assumes ram answers a read on the next clock edge
// Contract
// - call advances pc by two, pushes return address low byte first
// - call target: top five pc bits, opcode bits 7..5, second byte
// - jump loads same page-formed target and leaves the stack alone
// - add writes sum to accumulator, carry from bit 7, aux from bit 3
// - overflow set when carries out of bits 6 and 7 differ
// - add with carry also sums carry flag, same flag rules
// - byte and stores the and result, flags untouched
// - byte and supports six operand combinations
// - read-modify-write of a port reads the output latch
// - bit and clears carry on a zero source bit, else keeps it
// - complemented form uses inverted bit, bit itself unchanged
// - bit and source only by direct bit address in byte two
// - compare branches on inequality to next pc plus signed offset
// - compare sets carry on unsigned less-than, operands unchanged
// - compare supports four operand pairings
`timescale 1ns/100ps
`default_nettype none
module mce_exec (
  input wire logic clock, // core clock, 10 MHz
  input wire logic sys_rst, // async reset, active high
  input wire logic ins_valid, // instruction bytes present
  output logic ins_ready, // idle, takes an instruction
  input wire mce_pkg::mce_ins_t ins, // opcode and two following bytes
  output logic [15:0] fetch_pc, // address of next instruction
  output mce_pkg::mce_ram_req_t ram_req, // internal ram access
  input wire logic [7:0] ram_rdata, // ram read data, one cycle late
  input wire logic [31:0] port_pin, // port pins, asynchronous
  output logic [31:0] port_out, // port output latches
  output logic [7:0] acc_out, // accumulator
  output logic [7:0] psw_out, // status word
  output logic [7:0] sp_out // stack pointer
);
  mce_pkg::mce_state_t q;
  mce_pkg::mce_state_t n;
  logic take;
  logic sfr_hit;
  logic [7:0] sfr_val;
  logic [7:0] mval;
  logic [7:0] opnd;
  logic [7:0] other;
  logic [7:0] first;
  logic [7:0] second;
  logic cin;
  logic bitv;
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] low7;
  logic [15:0] br_pc;

  // working register address inside the selected bank
  function automatic logic [7:0] reg_addr(input logic [7:0] psw, input logic [2:0] r);
    return {3'h0, psw[mce_pkg::PSW_RS1:mce_pkg::PSW_RS0], r};
  endfunction

  function automatic logic is_port(input logic [7:0] a);
    return (a & mce_pkg::PORT_MASK) == mce_pkg::PORT_BASE;
  endfunction

  assign take = ins_valid && (q.fsm == mce_pkg::S_IDLE);
  assign ins_ready = (q.fsm == mce_pkg::S_IDLE);

  // special registers held here shadow the ram behind them
  assign sfr_hit = !q.ind && (q.addr == mce_pkg::SFR_ACC || q.addr == mce_pkg::SFR_PSW
                   || q.addr == mce_pkg::SFR_SP || is_port(q.addr));
  always_comb begin
    sfr_val = q.acc;
    if (q.addr == mce_pkg::SFR_PSW) begin
      sfr_val = q.psw;
    end else if (q.addr == mce_pkg::SFR_SP) begin
      sfr_val = q.sp;
    end else if (is_port(q.addr)) begin
      // latch on modify
      // only the byte and writes back, so only it reads the latch
      if (q.kind == mce_pkg::K_ANLD) begin
        sfr_val = q.latch[q.addr[mce_pkg::PORT_IDX_HI:mce_pkg::PORT_IDX_LO]];
      end else begin
        sfr_val = q.pin2[q.addr[mce_pkg::PORT_IDX_HI:mce_pkg::PORT_IDX_LO]];
      end
    end
  end

  // operand selection for the execute cycle
  assign mval = sfr_hit ? sfr_val : ram_rdata;
  assign opnd = q.fetch ? mval : q.imm;
  assign other = q.afirst ? q.acc : q.imm;
  assign first = q.afirst ? q.acc : mval;
  assign second = (q.fetch && q.afirst) ? mval : q.imm;
  assign bitv = mval[q.bpos] ^ (q.kind == mce_pkg::K_ANLCN);

  assign cin = (q.kind == mce_pkg::K_ADD_WITH_CARRY) && q.psw[mce_pkg::PSW_CY];
  assign sum = {1'b0, q.acc} + {1'b0, opnd} + {8'h00, cin};
  assign nib = {1'b0, q.acc[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
  assign low7 = {1'b0, q.acc[6:0]} + {1'b0, opnd[6:0]} + {7'h00, cin};
  // signed displacement from the advanced pc
  assign br_pc = q.pc + {{8{q.rel[7]}}, q.rel};

  // next-state logic for the whole block
  always_comb begin
    logic [3:0] lo;
    logic [15:0] len;
    logic [15:0] pcn;
    lo = ins.op[3:0];
    len = 16'h0001;
    pcn = q.pc;
    n = q;
    n.pin1 = port_pin;
    n.pin2 = q.pin1;
    case (q.fsm)
      mce_pkg::S_IDLE: begin
        if (take) begin
          n.kind = mce_pkg::K_NONE;
          n.fetch = 1'b0;
          n.afirst = 1'b0;
          n.ind = 1'b0;
          n.imm = ins.b1;
          n.rel = ins.b2;
          n.addr = ins.b1;
          n.bpos = ins.b1[2:0];
          if (lo == mce_pkg::LO_IMM || lo == mce_pkg::LO_DIR) begin
            len = 16'h0002;
          end
          if (lo >= mce_pkg::LO_IMM) begin
            n.fetch = (lo != mce_pkg::LO_IMM);
            n.afirst = (lo <= mce_pkg::LO_DIR);
            if (lo >= mce_pkg::LO_REG) begin
              n.addr = reg_addr(q.psw, ins.op[2:0]);
            end else if (lo >= mce_pkg::LO_IND) begin
              n.addr = reg_addr(q.psw, {2'b00, ins.op[0]});
              n.ind = 1'b1;
            end
            if (ins.op[7:4] == mce_pkg::G_ADD) begin
              n.kind = mce_pkg::K_ADD;
            end else if (ins.op[7:4] == mce_pkg::G_ADD_WITH_CARRY) begin
              n.kind = mce_pkg::K_ADD_WITH_CARRY;
            end else if (ins.op[7:4] == mce_pkg::G_ANL) begin
              n.kind = mce_pkg::K_ANLA;
            end else if (ins.op[7:4] == mce_pkg::G_COMPARE_BRANCH_UNEQUAL) begin
              n.kind = mce_pkg::K_COMPARE_BRANCH_UNEQUAL;
              len = 16'h0003;
            end
          end
          if (ins.op == mce_pkg::OP_ANL_DA || ins.op == mce_pkg::OP_ANL_DI) begin
            n.kind = mce_pkg::K_ANLD;
            n.fetch = 1'b1;
            n.afirst = (ins.op == mce_pkg::OP_ANL_DA);
            n.imm = ins.b2;
            len = (ins.op == mce_pkg::OP_ANL_DA) ? 16'h0002 : 16'h0003;
          end
          if (ins.op == mce_pkg::OP_ANL_CB || ins.op == mce_pkg::OP_ANL_CNB) begin
            n.kind = (ins.op == mce_pkg::OP_ANL_CB) ? mce_pkg::K_ANLC : mce_pkg::K_ANLCN;
            n.fetch = 1'b1;
            n.afirst = 1'b0;
            n.ind = 1'b0;
            len = 16'h0002;
            n.addr = ins.b1[7] ? (ins.b1 & mce_pkg::BIT_SFR_MASK)
                   : (mce_pkg::BIT_RAM_BASE + {4'h0, ins.b1[6:3]});
          end
          if (ins.op[4:0] == mce_pkg::CALL_LO || ins.op[4:0] == mce_pkg::JMP_LO) begin
            len = 16'h0002;
          end
          pcn = q.pc + len;
          n.pc = pcn;
          n.tgt = {ins.op[7:5], ins.b1};
          if (ins.op[4:0] == mce_pkg::CALL_LO) begin
            n.fsm = mce_pkg::S_PUSHL;
          end else if (ins.op[4:0] == mce_pkg::JMP_LO) begin
            n.pc = {pcn[15:11], ins.op[7:5], ins.b1};
          end else if (n.kind == mce_pkg::K_NONE) begin
            n.fsm = mce_pkg::S_IDLE;
          end else if (!n.fetch) begin
            n.fsm = mce_pkg::S_EXEC;
          end else begin
            n.fsm = n.ind ? mce_pkg::S_PTR : mce_pkg::S_RD;
          end
        end
      end
      mce_pkg::S_PTR: n.fsm = mce_pkg::S_PTRG;
      mce_pkg::S_PTRG: begin
        n.addr = ram_rdata;
        n.fsm = mce_pkg::S_RD;
      end
      mce_pkg::S_RD: n.fsm = mce_pkg::S_EXEC;
      mce_pkg::S_EXEC: begin
        n.fsm = mce_pkg::S_IDLE;
        case (q.kind)
          mce_pkg::K_ADD, mce_pkg::K_ADD_WITH_CARRY: begin
            n.acc = sum[7:0];
            n.psw[mce_pkg::PSW_CY] = sum[8];
            n.psw[mce_pkg::PSW_AC] = nib[4];
            n.psw[mce_pkg::PSW_OV] = low7[7] ^ sum[8];
          end
          mce_pkg::K_ANLA: begin
            n.acc = q.acc & opnd;
          end
          mce_pkg::K_ANLD: begin
            n.res = mval & other;
            if (!sfr_hit) begin
              n.fsm = mce_pkg::S_WB;
            end else if (q.addr == mce_pkg::SFR_ACC) begin
              n.acc = mval & other;
            end else if (q.addr == mce_pkg::SFR_PSW) begin
              n.psw = mval & other;
            end else if (q.addr == mce_pkg::SFR_SP) begin
              n.sp = mval & other;
            end else begin
              n.latch[q.addr[mce_pkg::PORT_IDX_HI:mce_pkg::PORT_IDX_LO]] = mval & other;
            end
          end
          mce_pkg::K_ANLC, mce_pkg::K_ANLCN: begin
            if (!bitv) begin
              n.psw[mce_pkg::PSW_CY] = 1'b0;
            end
          end
          mce_pkg::K_COMPARE_BRANCH_UNEQUAL: begin
            n.psw[mce_pkg::PSW_CY] = (first < second);
            if (first != second) begin
              n.pc = br_pc;
            end
          end
          default: n.fsm = mce_pkg::S_IDLE;
        endcase
      end
      mce_pkg::S_WB: n.fsm = mce_pkg::S_IDLE;
      mce_pkg::S_PUSHL: begin
        n.sp = q.sp + 8'h01;
        n.fsm = mce_pkg::S_PUSHH;
      end
      mce_pkg::S_PUSHH: begin
        n.sp = q.sp + 8'h01;
        n.pc = {q.pc[15:11], q.tgt};
        n.fsm = mce_pkg::S_IDLE;
      end
      default: n.fsm = mce_pkg::S_IDLE;
    endcase
  end

  // ram port driven from registered state only
  always_comb begin
    ram_req.en = (q.fsm == mce_pkg::S_PTR) || (q.fsm == mce_pkg::S_RD)
                 || (q.fsm == mce_pkg::S_WB) || (q.fsm == mce_pkg::S_PUSHL)
                 || (q.fsm == mce_pkg::S_PUSHH);
    ram_req.we = (q.fsm == mce_pkg::S_WB) || (q.fsm == mce_pkg::S_PUSHL)
                 || (q.fsm == mce_pkg::S_PUSHH);
    ram_req.addr = q.addr;
    ram_req.wdata = q.res;
    if (q.fsm == mce_pkg::S_PUSHL || q.fsm == mce_pkg::S_PUSHH) begin
      ram_req.addr = q.sp + 8'h01;
      ram_req.wdata = (q.fsm == mce_pkg::S_PUSHL) ? q.pc[7:0] : q.pc[15:8];
    end
  end

  // single state register; pins pass two flops before use
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
      q.sp <= mce_pkg::SP_RST;
    end else begin
      q <= n;
    end
  end

  assign fetch_pc = q.pc;
  assign port_out = q.latch;
  assign acc_out = q.acc;
  assign psw_out = q.psw;
  assign sp_out = q.sp;

  logic exec_add;
  assign exec_add = (q.fsm == mce_pkg::S_EXEC)
                    && (q.kind == mce_pkg::K_ADD || q.kind == mce_pkg::K_ADD_WITH_CARRY);

  push_order_a: assert property (@(posedge clock) disable iff (sys_rst)
    (q.fsm == mce_pkg::S_PUSHL) |-> ram_req.we && ram_req.addr == q.sp + 8'h01
    && ram_req.wdata == q.pc[7:0] ##1 ram_req.wdata == $past(q.pc[15:8]))
    else $error("call push order wrong");
  call_target_a: assert property (@(posedge clock) disable iff (sys_rst)
    take && ins.op[4:0] == mce_pkg::CALL_LO |-> ##3
    q.pc[10:0] == {$past(ins.op[7:5], 3), $past(ins.b1, 3)} && q.sp == $past(q.sp, 3) + 8'h02)
    else $error("call target wrong");
  jump_target_a: assert property (@(posedge clock) disable iff (sys_rst)
    take && ins.op[4:0] == mce_pkg::JMP_LO |=>
    q.pc[10:0] == {$past(ins.op[7:5]), $past(ins.b1)} && $stable(q.sp))
    else $error("jump target wrong");
  add_sum_a: assert property (@(posedge clock) disable iff (sys_rst)
    exec_add |=> q.acc == $past(q.acc + opnd + {7'h00, cin})
    && q.psw[mce_pkg::PSW_AC] == $past(nib[4]))
    else $error("add result wrong");
  add_ovf_a: assert property (@(posedge clock) disable iff (sys_rst)
    exec_add && !cin |=> q.psw[mce_pkg::PSW_OV] == ($past(q.acc[7]) == $past(opnd[7])
    && q.acc[7] != $past(q.acc[7])))
    else $error("overflow flag wrong");
  and_flags_a: assert property (@(posedge clock) disable iff (sys_rst)
    (q.fsm == mce_pkg::S_EXEC && q.kind == mce_pkg::K_ANLA) |=> $stable(q.psw))
    else $error("byte and touched flags");
  bit_and_a: assert property (@(posedge clock) disable iff (sys_rst)
    (q.fsm == mce_pkg::S_EXEC && (q.kind == mce_pkg::K_ANLC || q.kind == mce_pkg::K_ANLCN))
    |=> q.psw[mce_pkg::PSW_CY] == ($past(q.psw[mce_pkg::PSW_CY]) && $past(bitv)))
    else $error("bit and carry wrong");
  cmp_branch_a: assert property (@(posedge clock) disable iff (sys_rst)
    (q.fsm == mce_pkg::S_EXEC && q.kind == mce_pkg::K_COMPARE_BRANCH_UNEQUAL) |=>
    q.psw[mce_pkg::PSW_CY] == ($past(first) < $past(second))
    && q.pc == ($past(first) != $past(second) ? $past(br_pc) : $past(q.pc)))
    else $error("compare branch wrong");
  cmp_length_a: assert property (@(posedge clock) disable iff (sys_rst)
    take && ins.op[7:4] == mce_pkg::G_COMPARE_BRANCH_UNEQUAL && ins.op[3:0] >= mce_pkg::LO_IMM
    |=> q.pc == $past(q.pc) + 16'h0003)
    else $error("compare length wrong");
endmodule
`default_nettype wire

//--- testbench/mce_ram_model.sv
// internal data ram model answering the executor's ram port
// assumes reads answer one clock late and writes land on the request edge
`timescale 1ns/100ps
`default_nettype none
module mce_ram_model (
  input wire logic clock, // core clock
  input wire mce_pkg::mce_ram_req_t ram_req, // access from the executor
  output logic [7:0] ram_rdata // read data, valid for one cycle
);
  logic [7:0] mem [256];
  initial ram_rdata = 8'h00;
  // read data stands one cycle only; then the inverse shows, so stale use is caught
  always @(posedge clock) begin
    if (ram_req.en && ram_req.we) begin
      mem[ram_req.addr] <= ram_req.wdata;
    end
    if (ram_req.en && !ram_req.we) begin
      ram_rdata <= mem[ram_req.addr];
    end else begin
      ram_rdata <= ~ram_rdata;
    end
  end
endmodule
`default_nettype wire

//--- testbench/mcu_call_jump_arith_logic_exec_tb.sv
// self-checking bench for the call/jump/add/and/compare executor
// assumes the ram model beside it; bank 0 working registers live at ram 00h-07h
`timescale 1ns/100ps
`default_nettype none
module mcu_call_jump_arith_logic_exec_tb;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic ins_valid = 1'b0;
  logic ins_ready;
  mce_pkg::mce_ins_t ins = '0;
  logic [15:0] fetch_pc;
  mce_pkg::mce_ram_req_t ram_req;
  logic [7:0] ram_rdata;
  logic [31:0] port_pin = 32'h0000_0000;
  logic [31:0] port_out;
  logic [7:0] acc_out, psw_out, sp_out;
  int err_total = 0;
  int check_count = 0;
  logic [15:0] pc_e = 16'h0000;
  logic [2:0] fl_e; // expected carry, aux carry, overflow

  always #50 clock = ~clock;

  mce_exec dut (.clock(clock), .sys_rst(sys_rst), .ins_valid(ins_valid),
    .ins_ready(ins_ready), .ins(ins), .fetch_pc(fetch_pc), .ram_req(ram_req),
    .ram_rdata(ram_rdata), .port_pin(port_pin), .port_out(port_out),
    .acc_out(acc_out), .psw_out(psw_out), .sp_out(sp_out));
  mce_ram_model ram (.clock(clock), .ram_req(ram_req), .ram_rdata(ram_rdata));

  task automatic results();
    $display("checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic chk_fl();
    chk("flags", {13'h0000, psw_out[mce_pkg::PSW_CY], psw_out[mce_pkg::PSW_AC],
      psw_out[mce_pkg::PSW_OV]}, {13'h0000, fl_e});
  endtask

  // reference sum: carry, aux carry, overflow, result byte
  function automatic logic [10:0] add_ref(input logic [7:0] a, b, input logic c);
    logic [8:0] s;
    logic [4:0] l;
    logic [7:0] m;
    s = {1'b0, a} + {1'b0, b} + {8'h00, c};
    l = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, c};
    m = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, c};
    return {s[8], l[4], m[7] ^ s[8], s[7:0]};
  endfunction

  // bounded wait for idle, sampled at the falling edge where outputs are settled
  task automatic wait_idle();
    int n;
    n = 0;
    @(negedge clock);
    while (ins_ready !== 1'b1) begin
      n++;
      if (n > 40) begin
        err_total++;
        $display("wrong value ins_ready: expected 1, seen timeout");
        results();
      end
      @(negedge clock);
    end
  endtask

  // one instruction; ready is known high, so it is taken at the second edge
  task automatic issue(input logic [7:0] op, b1, b2, input logic [15:0] npc);
    wait_idle();
    @(posedge clock);
    ins_valid <= 1'b1;
    ins <= {op, b1, b2};
    @(posedge clock);
    ins_valid <= 1'b0;
    wait_idle();
    pc_e = npc;
    chk("fetch_pc", fetch_pc, pc_e);
  endtask

  task automatic step(input logic [7:0] op, b1, b2, input logic [1:0] len);
    issue(op, b1, b2, pc_e + {14'h0000, len});
  endtask

  // accumulator to v with carry c, built from and/add only
  task automatic setacc(input logic [7:0] v, input logic c);
    logic [7:0] p, w;
    logic [10:0] r;
    p = c ? 8'hFF : 8'h00;
    w = v + {7'h00, c};
    step(8'h54, 8'h00, 8'h00, 2'h2);
    step(8'h24, p, 8'h00, 2'h2);
    step(8'h24, w, 8'h00, 2'h2);
    r = add_ref(p, w, 1'b0);
    fl_e = r[10:8];
    chk("acc", {8'h00, acc_out}, {8'h00, r[7:0]});
    chk_fl();
  endtask

  // same operand at direct 40h, via r0 at 50h, and in r3
  task automatic fill(input logic [7:0] v);
    ram.mem[0] = 8'h50;
    ram.mem[8'h50] = v;
    ram.mem[8'h40] = v;
    ram.mem[3] = v;
  endtask

  task automatic t_call();
    chk("sp", {8'h00, sp_out}, 16'h0007);
    issue(8'h21, 8'h23, 8'h00, 16'h0123);
    chk("sp", {8'h00, sp_out}, 16'h0007);
    issue(8'h71, 8'h45, 8'h00, 16'h0345);
    chk("sp", {8'h00, sp_out}, 16'h0009);
    chk("ret lo", {8'h00, ram.mem[8]}, 16'h0025);
    chk("ret hi", {8'h00, ram.mem[9]}, 16'h0001);
    issue(8'hE1, 8'hFE, 8'h00, 16'h07FE);
    // the return address crosses into the next 2 K block, so does the target
    issue(8'h11, 8'h10, 8'h00, 16'h0810);
    chk("ret lo", {8'h00, ram.mem[10]}, 16'h0000);
    chk("ret hi", {8'h00, ram.mem[11]}, 16'h0008);
    chk("sp", {8'h00, sp_out}, 16'h000B);
  endtask

  task automatic t_add();
    logic [7:0] av [8] = '{8'hC3, 8'h0F, 8'h7F, 8'h80, 8'hC3, 8'h08, 8'h70, 8'hFE};
    logic [7:0] bv [8] = '{8'hAA, 8'h01, 8'h01, 8'h80, 8'hAA, 8'h07, 8'h0F, 8'h01};
    logic [7:0] lo [4] = '{8'h04, 8'h05, 8'h06, 8'h0B};
    logic [10:0] r;
    for (int i = 0; i < 8; i++) begin
      // carry is set each time, so a plain add must ignore it
      setacc(av[i], 1'b1);
      fill(bv[i]);
      r = add_ref(av[i], bv[i], i >= 4);
      step((i < 4 ? 8'h20 : 8'h30) | lo[i % 4], (i % 4 == 1) ? 8'h40 : bv[i], 8'h00,
        (i % 4 < 2) ? 2'h2 : 2'h1);
      fl_e = r[10:8];
      chk("acc", {8'h00, acc_out}, {8'h00, r[7:0]});
      chk_fl();
    end
  endtask

  task automatic t_anl();
    logic [7:0] op [6] = '{8'h54, 8'h55, 8'h56, 8'h5B, 8'h52, 8'h53};
    logic [7:0] ea, em;
    for (int i = 0; i < 6; i++) begin
      setacc(8'hC3, 1'b1);
      fill(8'h55);
      ea = (i < 4) ? 8'h41 : 8'hC3;
      em = (i == 4) ? 8'h41 : (i == 5) ? 8'h51 : 8'h55;
      step(op[i], (i == 0) ? 8'h55 : 8'h40, 8'h73,
        (i == 5) ? 2'h3 : (i == 2 || i == 3) ? 2'h1 : 2'h2);
      chk("acc", {8'h00, acc_out}, {8'h00, ea});
      chk("dest", {8'h00, ram.mem[8'h40]}, {8'h00, em});
      chk_fl();
    end
  endtask

  task automatic t_bit();
    logic [7:0] op [5] = '{8'h82, 8'hB0, 8'h82, 8'hB0, 8'h82};
    logic [7:0] ba [5] = '{8'h00, 8'h01, 8'hE7, 8'h00, 8'h01};
    logic cy [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    setacc(8'hC3, 1'b1);
    ram.mem[8'h20] = 8'h01;
    for (int i = 0; i < 5; i++) begin
      step(op[i], ba[i], 8'h00, 2'h2);
      fl_e[2] = cy[i];
      chk_fl();
    end
    chk("bit byte", {8'h00, ram.mem[8'h20]}, 16'h0001);
    chk("acc", {8'h00, acc_out}, 16'h00C3);
  endtask

  task automatic t_compare_branch_unequal();
    logic [7:0] op [4] = '{8'hB4, 8'hB5, 8'hB6, 8'hBF};
    logic [7:0] vv [3] = '{8'h56, 8'h60, 8'h61};
    logic [7:0] rl [3] = '{8'hF0, 8'h10, 8'h05};
    logic [15:0] nx;
    for (int m = 0; m < 4; m++) begin
      for (int j = 0; j < 3; j++) begin
        // equal case starts with carry set, so its clearing shows
        setacc(vv[j], j == 1);
        fill(8'h60);
        ram.mem[8'h50] = vv[j];
        ram.mem[7] = vv[j];
        nx = pc_e + 16'h0003;
        if (j != 1) begin
          nx = nx + {{8{rl[j][7]}}, rl[j]};
        end
        issue(op[m], (m == 1) ? 8'h40 : 8'h60, rl[j], nx);
        fl_e[2] = (j == 0);
        chk_fl();
        chk("operand", {8'h00, ram.mem[8'h50]}, {8'h00, vv[j]});
        chk("acc", {8'h00, acc_out}, {8'h00, vv[j]});
      end
    end
  endtask

  task automatic t_port();
    @(posedge clock);
    port_pin <= 32'hFFFF_FFFF;
    step(8'h53, 8'h90, 8'hFF, 2'h3);
    chk("port", port_out[15:0], 16'h0000);
    setacc(8'h34, 1'b1);
    @(posedge clock);
    port_pin <= 32'h0000_3400;
    repeat (4) @(posedge clock);
    issue(8'hB5, 8'h90, 8'hFE, pc_e + 16'h0003);
    fl_e[2] = 1'b0;
    chk_fl();
    @(posedge clock);
    port_pin <= 32'h0000_3500;
    repeat (4) @(posedge clock);
    issue(8'hB5, 8'h90, 8'hFE, pc_e + 16'h0001);
    fl_e[2] = 1'b1;
    chk_fl();
  endtask

  initial begin
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    t_call();
    t_add();
    t_anl();
    t_bit();
    t_compare_branch_unequal();
    t_port();
    results();
  end
endmodule
`default_nettype wire
